// [core/rre_pkg.sv]
// Package with constants and types for the rotate-right execution block
package rre_pkg;

    // Register byte offsets on the Avalon-MM slave
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_INSTR  = 6'h04;
    localparam logic [5:0] OFS_WREG   = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0C;
    localparam logic [5:0] OFS_BANK   = 6'h10;
    localparam logic [5:0] OFS_INDEX  = 6'h14;
    localparam logic [5:0] OFS_MADDR  = 6'h18;
    localparam logic [5:0] OFS_MDATA  = 6'h1C;
    localparam logic [5:0] OFS_STATE  = 6'h20;

    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 4;

    // Control and state bit positions
    localparam int CTRL_EXT   = 0;
    localparam int STATE_BUSY = 0;
    localparam int STATE_ILL  = 1;

    // Opcode upper-six-bit patterns
    localparam logic [5:0] OPC_RRC = 6'h0C;
    localparam logic [5:0] OPC_RRN = 6'h10;

    // Addressing constants
    localparam logic [7:0] ACC_SPLIT  = 8'h60;
    localparam logic [7:0] IDX_LIMIT  = 8'h5F;
    localparam logic [1:0] ACC_HIBANK = 2'h3;
    localparam int         MEM_AW     = 10;
    localparam int         MEM_DEPTH  = 1024;

    // Reset values
    localparam logic [7:0]        RST_BYTE  = 8'h00;
    localparam logic [15:0]       RST_INSTR = 16'h0000;
    localparam logic [MEM_AW-1:0] RST_ADDR  = 10'h000;

    // Instruction cycle phases
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_Q1   = 3'b001,
        PH_Q2   = 3'b010,
        PH_Q3   = 3'b011,
        PH_Q4   = 3'b100
    } rre_phase_t;

    // Decoded instruction fields
    typedef struct packed {
        logic       thru_carry;
        logic       dest_mem;
        logic       banked;
        logic [7:0] f;
    } rre_instr_t;

endpackage

// [core/rre_core.sv]
// Rotate-right execution datapath with Avalon-MM register slave and data memory
//
// Local design decisions: the Avalon-MM slave port and the register addresses.

module rre_core (
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);

    // Data memory, bank pointer selects the upper address bits for banked operands
    logic [7:0]               mem [0:rre_pkg::MEM_DEPTH-1];

    logic                     ext_q,     ext_d;
    logic [15:0]              instr_q,   instr_d;
    logic [7:0]               wreg_q,    wreg_d;
    logic [7:0]               status_q,  status_d;
    logic [1:0]               bank_q,    bank_d;
    logic [rre_pkg::MEM_AW-1:0] index_q, index_d;
    logic [rre_pkg::MEM_AW-1:0] maddr_q, maddr_d;
    logic                     ill_q,     ill_d;
    rre_pkg::rre_phase_t      ph_q,      ph_d;
    rre_pkg::rre_instr_t      dec_q,     dec_d;
    logic [rre_pkg::MEM_AW-1:0] ea_q,    ea_d;
    logic [7:0]               opr_q,     opr_d;
    logic [7:0]               res_q,     res_d;
    logic                     cout_q,    cout_d;
    logic                     wait_q,    wait_d;
    logic [31:0]              rdata_q,   rdata_d;

    logic                     req;
    logic                     accept;
    logic                     bus_wr;
    logic                     mem_we;
    logic [rre_pkg::MEM_AW-1:0] mem_wa;
    logic [7:0]               mem_wd;

    // Effective data address for a byte-oriented operand
    function automatic logic [rre_pkg::MEM_AW-1:0] eff_addr(
        input logic                     banked,
        input logic [7:0]               f,
        input logic                     ext,
        input logic [1:0]               bank,
        input logic [rre_pkg::MEM_AW-1:0] index
    );
        logic [rre_pkg::MEM_AW-1:0] a;
        a = {bank, f};
        if (!banked)
        begin
            if (ext && (f <= rre_pkg::IDX_LIMIT))
                a = index + {2'h0, f};
            else if (f < rre_pkg::ACC_SPLIT)
                a = {2'h0, f};
            else
                a = {rre_pkg::ACC_HIBANK, f};
        end
        return a;
    endfunction

    assign req    = i_avs_read | i_avs_write;
    // Requests are only taken while no instruction is in flight
    assign accept = req && wait_q && (ph_q == rre_pkg::PH_IDLE);
    assign bus_wr = i_avs_write && !wait_q;

    // Bus handshake: one stall cycle, then a one-cycle answer
    always_comb
    begin
        wait_d  = !accept;
        rdata_d = rdata_q;
        if (accept && i_avs_read)
        begin
            rdata_d = 32'h0000_0000;
            case (i_avs_address)
                rre_pkg::OFS_CTRL:   rdata_d[rre_pkg::CTRL_EXT] = ext_q;
                rre_pkg::OFS_INSTR:  rdata_d[15:0] = instr_q;
                rre_pkg::OFS_WREG:   rdata_d[7:0]  = wreg_q;
                rre_pkg::OFS_STATUS: rdata_d[7:0]  = status_q;
                rre_pkg::OFS_BANK:   rdata_d[1:0]  = bank_q;
                rre_pkg::OFS_INDEX:  rdata_d[rre_pkg::MEM_AW-1:0] = index_q;
                rre_pkg::OFS_MADDR:  rdata_d[rre_pkg::MEM_AW-1:0] = maddr_q;
                rre_pkg::OFS_MDATA:  rdata_d[7:0]  = mem[maddr_q];
                rre_pkg::OFS_STATE:
                begin
                    rdata_d[rre_pkg::STATE_ILL]  = ill_q;
                    rdata_d[rre_pkg::STATE_BUSY] = 1'b0;
                end
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Software-visible registers and the four-phase instruction cycle
    always_comb
    begin
        ext_d    = ext_q;
        instr_d  = instr_q;
        wreg_d   = wreg_q;
        status_d = status_q;
        bank_d   = bank_q;
        index_d  = index_q;
        maddr_d  = maddr_q;
        ill_d    = ill_q;
        ph_d     = ph_q;
        dec_d    = dec_q;
        ea_d     = ea_q;
        opr_d    = opr_q;
        res_d    = res_q;
        cout_d   = cout_q;
        mem_we   = 1'b0;
        mem_wa   = maddr_q;
        mem_wd   = i_avs_writedata[7:0];
        if (bus_wr)
        begin
            case (i_avs_address)
                rre_pkg::OFS_CTRL:   ext_d    = i_avs_writedata[rre_pkg::CTRL_EXT];
                rre_pkg::OFS_INSTR:
                begin
                    instr_d = i_avs_writedata[15:0];
                    ph_d    = rre_pkg::PH_Q1;              // Writing a word issues it
                end
                rre_pkg::OFS_WREG:   wreg_d   = i_avs_writedata[7:0];
                rre_pkg::OFS_STATUS: status_d = i_avs_writedata[7:0];
                rre_pkg::OFS_BANK:   bank_d   = i_avs_writedata[1:0];
                rre_pkg::OFS_INDEX:  index_d  = i_avs_writedata[rre_pkg::MEM_AW-1:0];
                rre_pkg::OFS_MADDR:  maddr_d  = i_avs_writedata[rre_pkg::MEM_AW-1:0];
                rre_pkg::OFS_MDATA:  mem_we   = 1'b1;
                default:             mem_we   = 1'b0;
            endcase
        end
        case (ph_q)
            rre_pkg::PH_IDLE: ph_d = ph_d;
            // Q1: decode; anything outside the two patterns is flagged and dropped
            rre_pkg::PH_Q1:
            begin
                dec_d.thru_carry = (instr_q[15:10] == rre_pkg::OPC_RRC);
                dec_d.dest_mem   = instr_q[9];
                dec_d.banked     = instr_q[8];
                dec_d.f          = instr_q[7:0];
                ea_d = eff_addr(instr_q[8], instr_q[7:0], ext_q, bank_q, index_q);
                if ((instr_q[15:10] == rre_pkg::OPC_RRC) ||
                    (instr_q[15:10] == rre_pkg::OPC_RRN))
                begin
                    ill_d = 1'b0;
                    ph_d  = rre_pkg::PH_Q2;
                end
                else
                begin
                    ill_d = 1'b1;
                    ph_d  = rre_pkg::PH_IDLE;
                end
            end
            // Q2: read the memory operand
            rre_pkg::PH_Q2:
            begin
                opr_d = mem[ea_q];
                ph_d  = rre_pkg::PH_Q3;
            end
            // Q3: rotate
            rre_pkg::PH_Q3:
            begin
                if (dec_q.thru_carry)
                begin
                    res_d  = {status_q[rre_pkg::FLAG_C], opr_q[7:1]};
                    cout_d = opr_q[0];
                end
                else
                begin
                    res_d  = {opr_q[0], opr_q[7:1]};
                    cout_d = status_q[rre_pkg::FLAG_C];
                end
                ph_d = rre_pkg::PH_Q4;
            end
            // Q4: write destination and commit flags from the same result at the same edge
            rre_pkg::PH_Q4:
            begin
                if (dec_q.dest_mem)
                begin
                    mem_we = 1'b1;
                    mem_wa = ea_q;
                    mem_wd = res_q;
                end
                else
                    wreg_d = res_q;
                // Flags land with the writeback edge so they describe this result
                status_d[rre_pkg::FLAG_N] = res_q[7];
                status_d[rre_pkg::FLAG_Z] = (res_q == 8'h00);
                status_d[rre_pkg::FLAG_C] = cout_q;
                ph_d = rre_pkg::PH_IDLE;
            end
            default: ph_d = rre_pkg::PH_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            ext_q    <= 1'b0;
            instr_q  <= rre_pkg::RST_INSTR;
            wreg_q   <= rre_pkg::RST_BYTE;
            status_q <= rre_pkg::RST_BYTE;
            bank_q   <= 2'h0;
            index_q  <= rre_pkg::RST_ADDR;
            maddr_q  <= rre_pkg::RST_ADDR;
            ill_q    <= 1'b0;
            ph_q     <= rre_pkg::PH_IDLE;
            dec_q    <= '0;
            ea_q     <= rre_pkg::RST_ADDR;
            opr_q    <= rre_pkg::RST_BYTE;
            res_q    <= rre_pkg::RST_BYTE;
            cout_q   <= 1'b0;
            wait_q   <= 1'b1;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            ext_q    <= ext_d;
            instr_q  <= instr_d;
            wreg_q   <= wreg_d;
            status_q <= status_d;
            bank_q   <= bank_d;
            index_q  <= index_d;
            maddr_q  <= maddr_d;
            ill_q    <= ill_d;
            ph_q     <= ph_d;
            dec_q    <= dec_d;
            ea_q     <= ea_d;
            opr_q    <= opr_d;
            res_q    <= res_d;
            cout_q   <= cout_d;
            wait_q   <= wait_d;
            rdata_q  <= rdata_d;
        end
    end

    // Memory write port; contents are not reset
    always_ff @(posedge i_core_clk)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = wait_q;

endmodule

// [tb/rre_core_asserts.sv]
// Bus timing and readback checker for the rotate-right execution block
module rre_core_asserts (
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic [5:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    logic       ext_q, ext_d, ill_q, ill_d, wa, ra;
    logic [1:0] bank_q, bank_d;
    logic [7:0] sts_q, sts_d;
    assign wa = i_avs_write && !o_avs_waitrequest;
    assign ra = i_avs_read && !o_avs_waitrequest;
    // Shadow of what software last wrote, so readbacks can be judged
    always_comb
    begin
        ext_d  = ext_q;
        bank_d = bank_q;
        sts_d  = sts_q;
        ill_d  = ill_q;
        if (wa && i_avs_address == rre_pkg::OFS_CTRL) ext_d = i_avs_writedata[0];
        if (wa && i_avs_address == rre_pkg::OFS_BANK) bank_d = i_avs_writedata[1:0];
        if (wa && i_avs_address == rre_pkg::OFS_STATUS) sts_d = i_avs_writedata[7:0];
        if (wa && i_avs_address == rre_pkg::OFS_INSTR)
            ill_d = !(i_avs_writedata[15:10] == rre_pkg::OPC_RRC
                   || i_avs_writedata[15:10] == rre_pkg::OPC_RRN);
    end
    // Registers only; reset matches the zero reset values of the shadowed design registers
    always_ff @(posedge i_core_clk)
    begin
        ext_q  <= i_sys_rst ? 1'b0 : ext_d;
        bank_q <= i_sys_rst ? 2'h0 : bank_d;
        sts_q  <= i_sys_rst ? 8'h00 : sts_d;
        ill_q  <= i_sys_rst ? 1'b0 : ill_d;
    end
    a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer cycle longer than one clock");
    a_instr_busy: assert property (wa && !ill_d
        && i_avs_address == rre_pkg::OFS_INSTR |=> o_avs_waitrequest [*4])
        else $error("bus answered during instruction phases");
    a_skip_short: assert property (wa && ill_d
        && i_avs_address == rre_pkg::OFS_INSTR |=> o_avs_waitrequest [*2])
        else $error("bus answered before a dropped word was decoded");
    a_answer_bound: assert property ((i_avs_read || i_avs_write)
        |-> ##[0:8] !o_avs_waitrequest) else $error("request not answered in time");
    a_rdata_holds: assert property ($changed(o_avs_readdata) |-> ra)
        else $error("read data moved outside a read answer");
    a_decode_flag: assert property (ra && i_avs_address == rre_pkg::OFS_STATE
        |-> o_avs_readdata[1] == ill_q) else $error("opcode recognition flag wrong");
    a_ext_back: assert property (ra && i_avs_address == rre_pkg::OFS_CTRL
        |-> o_avs_readdata[0] == ext_q) else $error("extended set enable readback wrong");
    a_bank_back: assert property (ra && i_avs_address == rre_pkg::OFS_BANK
        |-> o_avs_readdata[1:0] == bank_q) else $error("bank pointer readback wrong");
    a_status_keep: assert property (ra && i_avs_address == rre_pkg::OFS_STATUS
        |-> (o_avs_readdata[7:0] & 8'hEA) == (sts_q & 8'hEA))
        else $error("status bits outside carry sign zero changed");
endmodule
bind rre_core rre_core_asserts u_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest));

// [tb/rre_core_tb.sv]
// Self-checking bench for the rotate-right execution block
module rre_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, rd, wr_en, wreq;
    logic [5:0]  addr;
    logic [31:0] wd, rdata;
    int          mismatches, n_compared;
    rre_core u_rre_core (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr_en), .i_avs_writedata(wd),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq));
    // 10 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One bus cycle; waitrequest is sampled at rising edges, data taken and request
    // released at the same edge that sees it low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        q = 32'h0000_0000;
        @(posedge clk);
        rd <= !w;
        wr_en <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (wreq !== 1'b0)
        begin
            mismatches++;
            stop_test();
        end
        else
        begin
            q = rdata;
            rd <= 1'b0;
            wr_en <= 1'b0;
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask
    task automatic ms(input logic [9:0] a, input logic [7:0] d);
        wr(rre_pkg::OFS_MADDR, {22'h0, a});
        wr(rre_pkg::OFS_MDATA, {24'h0, d});
    endtask
    task automatic mc(input logic [9:0] a, input logic [31:0] e);
        wr(rre_pkg::OFS_MADDR, {22'h0, a});
        rc("mem", rre_pkg::OFS_MDATA, e);
    endtask
    task automatic ex(input logic [15:0] i);
        wr(rre_pkg::OFS_INSTR, {16'h0, i});
    endtask
    // Carry in and out, both destinations, zero result
    task automatic t_carry;
        wr(rre_pkg::OFS_STATUS, 32'hEB);
        ms(10'h010, 8'h01);
        ex(16'h3010);
        rc("wreg", rre_pkg::OFS_WREG, 32'h80);
        rc("status", rre_pkg::OFS_STATUS, 32'hFB);
        mc(10'h010, 32'h01);
        wr(rre_pkg::OFS_STATUS, 32'hEA);
        ms(10'h011, 8'h01);
        ex(16'h3211);
        mc(10'h011, 32'h00);
        rc("status", rre_pkg::OFS_STATUS, 32'hEF);
        $display("carry test done");
    endtask
    // Plain rotate wraps bit 0 and leaves carry alone
    task automatic t_plain;
        wr(rre_pkg::OFS_STATUS, 32'h01);
        ms(10'h012, 8'hD7);
        ex(16'h4212);
        mc(10'h012, 32'hEB);
        rc("status", rre_pkg::OFS_STATUS, 32'h11);
        wr(rre_pkg::OFS_STATUS, 32'h00);
        ms(10'h013, 8'h01);
        ex(16'h4013);
        rc("wreg", rre_pkg::OFS_WREG, 32'h80);
        rc("status", rre_pkg::OFS_STATUS, 32'h10);
        mc(10'h013, 32'h01);
        $display("plain test done");
    endtask
    // Bank pointer and upper access bank
    task automatic t_bank;
        wr(rre_pkg::OFS_BANK, 32'h2);
        ms(10'h205, 8'h02);
        ms(10'h005, 8'h40);
        ex(16'h4305);
        mc(10'h205, 32'h01);
        mc(10'h005, 32'h40);
        ms(10'h380, 8'h04);
        ex(16'h4280);
        mc(10'h380, 32'h02);
        rc("bank", rre_pkg::OFS_BANK, 32'h2);
        $display("bank test done");
    endtask
    // Indexed offset at the top legal offset
    task automatic t_index;
        wr(rre_pkg::OFS_CTRL, 32'h1);
        wr(rre_pkg::OFS_INDEX, 32'h100);
        ms(10'h15F, 8'h08);
        ms(10'h05F, 8'h10);
        ex(16'h425F);
        mc(10'h15F, 32'h04);
        mc(10'h05F, 32'h10);
        rc("ctrl", rre_pkg::OFS_CTRL, 32'h1);
        wr(rre_pkg::OFS_CTRL, 32'h0);
        $display("index test done");
    endtask
    // A rotate-left word is not executed and is flagged
    task automatic t_decode;
        ex(16'h3410);
        rc("state", rre_pkg::OFS_STATE, 32'h2);
        rc("wreg", rre_pkg::OFS_WREG, 32'h80);
        ex(16'h4013);
        rc("state", rre_pkg::OFS_STATE, 32'h0);
        rc("unmapped", 6'h24, 32'h0);
        $display("decode test done");
    endtask
    // Reset, then the scenarios in turn
    initial
    begin
        rst = 1'b1;
        rd = 1'b0;
        wr_en = 1'b0;
        addr = 6'h00;
        wd = 32'h0;
        mismatches = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_carry();
        t_plain();
        t_bank();
        t_index();
        t_decode();
        stop_test();
    end
endmodule
